// File: logic/protected_register_write_guard.v
// write guard for the protected control registers and the peripheral wait control
//
// Summary of operation
// (RULE1) power save, cpu clock and watchdog mode registers alone are protected.
// (RULE2) a command write permits only the next protected write; later ones need rearming.
// (RULE3) command register takes byte writes only; reading it gives no stored contents.
// (RULE4) interrupt acknowledge is held off between command write and the next write.
// (RULE5) any value written to the command register arms; the data is ignored.
// (RULE6) protected write without a preceding command write sets the error flag.
// (RULE7) first write after arming to a non-protected register sets the error flag.
// (RULE8) reads between arming and power save or clock write cancel nothing.
// (RULE9) error flag cleared by writing 0 or reset, otherwise sticky.
// (RULE10) writing 0 to the flag right after arming leaves it 0.
// (RULE11) two back-to-back command writes set the error flag.
// (RULE12) status register is 8 bits, reset 0, flag in bit 0, rest read 0.
// (RULE13) protected registers read back directly with no sequence.
// (RULE14) software quiets dma, arms, stores, then runs five no-operations.
// (RULE15) peripheral access is 3 clocks plus the programmed wait count.
// (RULE16) wait control register is 8-bit read/write, resets to 77H.
// (RULE17) software picks one wait at or above 16.6 MHz, none below.
// (RULE18) software programs wait control before any other register.
// (RULE19) any peripheral write consumes the armed state; reset clears it.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps

`include "guard_consts.vh"

module protected_register_write_guard #(
    parameter DATA_W = 8,
    parameter ADDR_W = 32
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire [ADDR_W-1:0] addr_in,
    input wire [DATA_W-1:0] wdata_in,
    input wire [1:0] size_in,
    input wire bitop_in,
    input wire wr_in,
    input wire rd_in,
    output reg [DATA_W-1:0] rdata_out,
    output wire int_ack_hold_out,
    output wire irq_out,
    output reg [DATA_W-1:0] power_save_ctrl_out,
    output reg [DATA_W-1:0] cpu_clock_ctrl_out,
    output reg [DATA_W-1:0] watchdog_mode_ctrl_out,
    output reg protection_error_flag_out,
    output reg [3:0] periph_waits_out,
    output reg [4:0] access_clocks_out
);

    // address decode
    wire hit_wait;
    wire hit_cmd;
    wire hit_sys;
    wire hit_psc;
    wire hit_pcc;
    wire hit_wdt;
    wire hit_ists;
    wire hit_imsk;
    wire hit_prot;

    assign hit_wait = (addr_in == `ADDR_WAIT_CTRL);
    assign hit_cmd = (addr_in == `ADDR_PROTECT_CMD);
    assign hit_sys = (addr_in == `ADDR_SYS_STATUS);
    assign hit_psc = (addr_in == `ADDR_POWER_SAVE);
    assign hit_pcc = (addr_in == `ADDR_CPU_CLOCK);
    assign hit_wdt = (addr_in == `ADDR_WATCHDOG);
    assign hit_ists = (addr_in == `ADDR_IRQ_STATUS);
    assign hit_imsk = (addr_in == `ADDR_IRQ_MASK);
    assign hit_prot = hit_psc | hit_pcc | hit_wdt; // RULE1

    // a bit-manipulation store arrives as a full-byte write and is judged like one
    wire store_req;
    assign store_req = wr_in | bitop_in; // RULE7

    // guard sequencer states; code 2'b11 is never entered
    localparam [1:0] GUARD_IDLE = 2'b00;
    localparam [1:0] GUARD_ARMED = 2'b01;
    localparam [1:0] GUARD_ARMED_READ = 2'b10;

    // reset image of the status byte; only the flag bit is stored
    localparam [7:0] SYS_STATUS_RESET = `RST_SYS_STATUS;

    // guard state
    reg [1:0] guard_state;
    reg [1:0] next_guard_state;
    wire armed;
    wire read_seen;
    reg [DATA_W-1:0] peripheral_wait_ctrl;
    reg [`EVT_COUNT-1:0] irq_status;
    reg [`EVT_COUNT-1:0] irq_mask;

    wire cmd_byte_wr;
    wire prot_ok;
    wire prot_bad;
    wire nonprot_after_arm;
    wire sys_clear;
    wire set_err;
    wire clr_err;
    wire [`EVT_COUNT-1:0] event_pulse;
    wire wait_wr_ok;
    wire ists_read;

    // only a byte-wide store arms; the data itself is a dummy
    assign cmd_byte_wr = store_req & hit_cmd & (size_in == `SIZE_BYTE); // RULE3 RULE5

    // watchdog write must follow the command write with no read between
    assign prot_ok = store_req & hit_prot & armed & ~(hit_wdt & read_seen); // RULE2 RULE8

    assign prot_bad = store_req & hit_prot & ~prot_ok; // RULE6

    // includes a second command write while armed
    assign nonprot_after_arm = store_req & ~hit_prot & armed; // RULE7 RULE11

    assign sys_clear = store_req & hit_sys & ~wdata_in[`BIT_PROT_ERR]; // RULE9

    assign set_err = prot_bad | nonprot_after_arm;

    // an explicit zero write beats a simultaneous error
    assign clr_err = sys_clear; // RULE10

    assign event_pulse[`EVT_ERROR] = set_err;
    assign event_pulse[`EVT_ACCEPT] = prot_ok;

    // hold off interrupt acknowledge while the guarded store is pending
    assign int_ack_hold_out = armed; // RULE4

    assign armed = (guard_state == GUARD_ARMED) | (guard_state == GUARD_ARMED_READ);
    assign read_seen = (guard_state == GUARD_ARMED_READ);

    assign irq_out = |(irq_status & irq_mask);

    // a half or word store would tear the byte, so only byte stores load it
    assign wait_wr_ok = store_req & hit_wait & (size_in == `SIZE_BYTE); // RULE16

    assign ists_read = rd_in & hit_ists;

    // armed state: set by a command write, consumed by any write
    always @* begin
        next_guard_state = guard_state;
        case (guard_state)
            GUARD_IDLE: begin
                if (cmd_byte_wr) begin
                    next_guard_state = GUARD_ARMED; // RULE2 RULE5
                end
            end
            GUARD_ARMED: begin
                if (store_req) begin
                    // a repeated command write consumes rather than rearms
                    next_guard_state = GUARD_IDLE; // RULE2 RULE11 RULE19
                end else if (rd_in) begin
                    // reads keep the armed state; only the watchdog store cares
                    next_guard_state = GUARD_ARMED_READ; // RULE8
                end
            end
            GUARD_ARMED_READ: begin
                if (store_req) begin
                    next_guard_state = GUARD_IDLE; // RULE19
                end
            end
            default: begin
                // the unused code falls back to idle rather than hanging armed
                next_guard_state = GUARD_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            guard_state <= GUARD_IDLE; // RULE19
        end else begin
            guard_state <= next_guard_state;
        end
    end

    // protected registers
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            power_save_ctrl_out <= `RST_POWER_SAVE;
            cpu_clock_ctrl_out <= `RST_CPU_CLOCK;
            watchdog_mode_ctrl_out <= `RST_WATCHDOG;
        end else if (prot_ok) begin
            if (hit_psc) begin
                power_save_ctrl_out <= wdata_in; // RULE2
            end
            if (hit_pcc) begin
                cpu_clock_ctrl_out <= wdata_in; // RULE2
            end
            if (hit_wdt) begin
                watchdog_mode_ctrl_out <= wdata_in; // RULE2
            end
        end
    end

    // protection error flag
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            protection_error_flag_out <= SYS_STATUS_RESET[`BIT_PROT_ERR]; // RULE9 RULE12
        end else if (clr_err) begin
            protection_error_flag_out <= 1'b0; // RULE10
        end else if (set_err) begin
            protection_error_flag_out <= 1'b1; // RULE6 RULE7 RULE11
        end
    end

    // wait control and derived access length
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            peripheral_wait_ctrl <= `RST_WAIT_CTRL; // RULE16
        end else if (wait_wr_ok) begin
            peripheral_wait_ctrl <= wdata_in; // RULE16
        end
    end

    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            periph_waits_out <= 4'h0;
            access_clocks_out <= `BASE_ACCESS_CLOCKS;
        end else begin
            periph_waits_out <= peripheral_wait_ctrl[`WAIT_FIELD_MSB:0]; // RULE15
            access_clocks_out <= `BASE_ACCESS_CLOCKS
                + {1'b0, peripheral_wait_ctrl[`WAIT_FIELD_MSB:0]}; // RULE15
        end
    end

    // interrupt status, one sticky bit per event
    genvar gi;
    generate
        for (gi = 0; gi < `EVT_COUNT; gi = gi + 1) begin : g_evt
            always @(posedge clk_sys_in) begin
                if (!reset_n_in) begin
                    irq_status[gi] <= 1'b0;
                end else if (event_pulse[gi]) begin
                    // a new event beats the read that clears
                    irq_status[gi] <= 1'b1;
                end else if (ists_read) begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            irq_mask <= `RST_IRQ_MASK;
        end else if (store_req && hit_imsk) begin
            irq_mask <= wdata_in[`EVT_COUNT-1:0];
        end
    end

    // read select codes, one per mapped register
    localparam [3:0] RSEL_NONE = 4'h0;
    localparam [3:0] RSEL_WAIT = 4'h1;
    localparam [3:0] RSEL_CMD = 4'h2;
    localparam [3:0] RSEL_SYS = 4'h3;
    localparam [3:0] RSEL_PSC = 4'h4;
    localparam [3:0] RSEL_PCC = 4'h5;
    localparam [3:0] RSEL_WDT = 4'h6;
    localparam [3:0] RSEL_ISTS = 4'h7;
    localparam [3:0] RSEL_IMSK = 4'h8;

    // full status byte; spare bits are tied low so a byte read sees zeros
    wire [7:0] sys_status_image;

    genvar gs;
    generate
        for (gs = 0; gs < 8; gs = gs + 1) begin : g_sys_bit
            if (gs == `BIT_PROT_ERR) begin : g_flag
                assign sys_status_image[gs] = protection_error_flag_out; // RULE12
            end else begin : g_spare
                assign sys_status_image[gs] = 1'b0; // RULE12
            end
        end
    endgenerate

    // read data, valid in the cycle after the strobe only
    reg [3:0] read_sel;
    reg [DATA_W-1:0] next_rdata;

    always @* begin
        read_sel = RSEL_NONE;
        if (rd_in) begin
            if (hit_wait) begin
                read_sel = RSEL_WAIT;
            end else if (hit_cmd) begin
                read_sel = RSEL_CMD;
            end else if (hit_sys) begin
                read_sel = RSEL_SYS;
            end else if (hit_psc) begin
                read_sel = RSEL_PSC;
            end else if (hit_pcc) begin
                read_sel = RSEL_PCC;
            end else if (hit_wdt) begin
                read_sel = RSEL_WDT;
            end else if (hit_ists) begin
                read_sel = RSEL_ISTS;
            end else if (hit_imsk) begin
                read_sel = RSEL_IMSK;
            end
        end
    end

    always @* begin
        next_rdata = {DATA_W{1'b0}};
        case (read_sel)
            RSEL_WAIT: begin
                next_rdata = peripheral_wait_ctrl;
            end
            RSEL_CMD: begin
                // no storage behind the command register
                next_rdata = `CMD_READ_VALUE; // RULE3
            end
            RSEL_SYS: begin
                next_rdata = sys_status_image; // RULE12
            end
            RSEL_PSC: begin
                next_rdata = power_save_ctrl_out; // RULE13
            end
            RSEL_PCC: begin
                next_rdata = cpu_clock_ctrl_out; // RULE13
            end
            RSEL_WDT: begin
                next_rdata = watchdog_mode_ctrl_out; // RULE13
            end
            RSEL_ISTS: begin
                next_rdata[`EVT_COUNT-1:0] = irq_status;
            end
            RSEL_IMSK: begin
                next_rdata[`EVT_COUNT-1:0] = irq_mask;
            end
            default: begin
                // unmapped or idle: the bus reads zero
                next_rdata = {DATA_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            rdata_out <= {DATA_W{1'b0}};
        end else begin
            rdata_out <= next_rdata;
        end
    end

endmodule // protected_register_write_guard

// File: logic/guard_consts.vh
// register map, field positions and reset values for the write guard
`ifndef GUARD_CONSTS_VH
`define GUARD_CONSTS_VH

`define ADDR_WAIT_CTRL 32'hFFFFF06E
`define ADDR_PROTECT_CMD 32'hFFFFF1FC
`define ADDR_SYS_STATUS 32'hFFFFF802
`define ADDR_POWER_SAVE 32'hFFFFF1F0
`define ADDR_CPU_CLOCK 32'hFFFFF1F4
`define ADDR_WATCHDOG 32'hFFFFF1F8
`define ADDR_IRQ_STATUS 32'hFFFFF810
`define ADDR_IRQ_MASK 32'hFFFFF814

`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

`define RST_WAIT_CTRL 8'h77
`define RST_SYS_STATUS 8'h00
`define RST_POWER_SAVE 8'h00
`define RST_CPU_CLOCK 8'h00
`define RST_WATCHDOG 8'h00
`define RST_IRQ_MASK 2'h0
`define CMD_READ_VALUE 8'h00

`define BIT_PROT_ERR 0
`define EVT_ERROR 0
`define EVT_ACCEPT 1
`define EVT_COUNT 2

`define BASE_ACCESS_CLOCKS 5'h03
`define WAIT_FIELD_MSB 3

`endif

// File: dv/cpu_core_model.sv
// cpu core model issuing single-cycle peripheral bus accesses
`timescale 1ns/100ps
module cpu_core_model (
    input wire clk_sys_in,
    output logic [31:0] addr_out,
    output logic [7:0] wdata_out,
    output logic [1:0] size_out,
    output logic bitop_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        {addr_out, wdata_out, size_out, bitop_out, wr_out, rd_out} = '0;
    end
    // one cycle per call, entered just after an edge; idle cycles scramble the released lines
    task automatic op(input logic w, input logic r, input logic [31:0] a, input logic [7:0] d, input logic [1:0] s);
        wr_out <= w;
        rd_out <= r;
        addr_out <= (w | r) ? a : ~addr_out;
        wdata_out <= w ? d : ~wdata_out;
        size_out <= s;
        bitop_out <= w & d[0];
        @(posedge clk_sys_in);
    endtask
endmodule // cpu_core_model

// File: dv/guard_properties.sv
// assertions on the write guard ports
`timescale 1ns/100ps
`include "guard_consts.vh"
module guard_properties (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire [31:0] addr_in,
    input wire [7:0] wdata_in,
    input wire [1:0] size_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire int_ack_hold_out,
    input wire [7:0] power_save_ctrl_out,
    input wire protection_error_flag_out,
    input wire [3:0] periph_waits_out,
    input wire [4:0] access_clocks_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    sequence arm; wr_in && addr_in == `ADDR_PROTECT_CMD && size_in == `SIZE_BYTE && !int_ack_hold_out; endsequence
    sequence psc_wr; wr_in && addr_in == `ADDR_POWER_SAVE; endsequence
    sequence wait_wr; wr_in && addr_in == `ADDR_WAIT_CTRL && size_in == `SIZE_BYTE; endsequence
    chk_arm_hold: assert property (arm |=> int_ack_hold_out) else $error("guard not armed");
    chk_armed_store: assert property (arm ##1 psc_wr |=> power_save_ctrl_out == $past(wdata_in))
        else $error("armed store lost");
    chk_one_shot: assert property (int_ack_hold_out && wr_in |=> !int_ack_hold_out)
        else $error("guard stays armed");
    chk_unarmed_err: assert property (wr_in && !int_ack_hold_out && addr_in == `ADDR_POWER_SAVE
        |=> protection_error_flag_out && $stable(power_save_ctrl_out)) else $error("unarmed store taken");
    chk_bad_target: assert property ((int_ack_hold_out and wait_wr) |=> protection_error_flag_out)
        else $error("wrong target not flagged");
    chk_double_cmd: assert property (int_ack_hold_out && wr_in && addr_in == `ADDR_PROTECT_CMD
        |=> protection_error_flag_out && !int_ack_hold_out) else $error("double command not flagged");
    chk_zero_clear: assert property (wr_in && addr_in == `ADDR_SYS_STATUS && !wdata_in[0]
        |=> !protection_error_flag_out) else $error("flag not cleared");
    chk_flag_sticky: assert property (protection_error_flag_out && !(wr_in && addr_in == `ADDR_SYS_STATUS)
        |=> protection_error_flag_out) else $error("flag dropped");
    chk_status_read: assert property (rd_in && addr_in == `ADDR_SYS_STATUS |=> rdata_out[7:1] == 7'h00)
        else $error("status spare bits set");
    chk_wait_follow: assert property (wait_wr ##1
        !(wr_in && addr_in == `ADDR_WAIT_CTRL && size_in == `SIZE_BYTE)
        |=> periph_waits_out == $past(wdata_in[3:0], 2)) else $error("wait count not taken");
    chk_clock_sum: assert property (access_clocks_out == periph_waits_out + `BASE_ACCESS_CLOCKS)
        else $error("access clocks wrong");
endmodule // guard_properties
bind protected_register_write_guard guard_properties chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .size_in(size_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .int_ack_hold_out(int_ack_hold_out), .power_save_ctrl_out(power_save_ctrl_out),
    .protection_error_flag_out(protection_error_flag_out), .periph_waits_out(periph_waits_out),
    .access_clocks_out(access_clocks_out));

// File: dv/protected_register_write_guard_test.sv
// self-checking bench for the protected register write guard
`timescale 1ns/100ps
`include "guard_consts.vh"
module protected_register_write_guard_test;
    logic clk_sys_in = 0, reset_n_in = 0, rd_q = 0;
    wire [31:0] addr;
    wire [7:0] wdata, rdata;
    wire [1:0] size;
    wire bitop, wr, rd, hold, irq;
    wire [4:0] acc;
    logic [7:0] d, exp_q[$];
    logic [31:0] preg[3] = '{`ADDR_POWER_SAVE, `ADDR_CPU_CLOCK, `ADDR_WATCHDOG};
    int errors = 0, n_compared = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    cpu_core_model cpu (.clk_sys_in(clk_sys_in), .addr_out(addr), .wdata_out(wdata), .size_out(size),
        .bitop_out(bitop), .wr_out(wr), .rd_out(rd));
    protected_register_write_guard uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .addr_in(addr),
        .wdata_in(wdata), .size_in(size), .bitop_in(bitop), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .int_ack_hold_out(hold), .irq_out(irq), .power_save_ctrl_out(), .cpu_clock_ctrl_out(),
        .watchdog_mode_ctrl_out(), .protection_error_flag_out(), .periph_waits_out(), .access_clocks_out(acc));
    task automatic stop_test();
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [31:0] a, input logic [7:0] v);
        cpu.op(1, 0, a, v, `SIZE_BYTE);
    endtask
    task automatic r(input logic [31:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        cpu.op(0, 1, a, 8'h00, `SIZE_BYTE);
    endtask
    // read data stand only in the cycle after the strobe
    always @(negedge clk_sys_in) begin
        if (rd_q) compare(rdata, exp_q.pop_front());
        rd_q = rd;
    end
    initial begin
        repeat (3000) @(posedge clk_sys_in);
        errors++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h5408));
        repeat (5) @(posedge clk_sys_in);
        reset_n_in <= 1;
        r(`ADDR_WAIT_CTRL, `RST_WAIT_CTRL);
        r(`ADDR_SYS_STATUS, `RST_SYS_STATUS);
        r(`ADDR_PROTECT_CMD, `CMD_READ_VALUE);
        w(`ADDR_WAIT_CTRL, 8'h01);
        r(`ADDR_WAIT_CTRL, 8'h01);
        #1 compare({3'h0, acc}, 8'h04);
        w(`ADDR_IRQ_MASK, 8'h03);
        foreach (preg[i]) begin
            d = $urandom;
            w(`ADDR_PROTECT_CMD, ~d);
            #1 compare({7'h00, hold}, 8'h01);
            w(preg[i], d);
            repeat (5) cpu.op(0, 0, 0, 0, 0);
            w(preg[i], ~d);
            r(preg[i], d);
            r(`ADDR_SYS_STATUS, 8'h01);
            #1 compare({7'h00, irq}, 8'h01);
            r(`ADDR_IRQ_STATUS, 8'h03);
            w(`ADDR_SYS_STATUS, 8'hFE);
            r(`ADDR_SYS_STATUS, 8'h00);
        end
        w(`ADDR_IRQ_MASK, 8'h00);
        w(`ADDR_PROTECT_CMD, d);
        r(`ADDR_SYS_STATUS, 8'h00);
        w(`ADDR_WATCHDOG, ~d);
        r(`ADDR_WATCHDOG, d);
        #1 compare({7'h00, irq}, 8'h00);
        w(`ADDR_PROTECT_CMD, d);
        r(`ADDR_SYS_STATUS, 8'h01);
        w(`ADDR_POWER_SAVE, 8'h5A);
        w(`ADDR_PROTECT_CMD, d);
        w(`ADDR_SYS_STATUS, 8'h00);
        r(`ADDR_SYS_STATUS, 8'h00);
        w(`ADDR_PROTECT_CMD, d);
        w(`ADDR_WAIT_CTRL, 8'h00);
        r(`ADDR_SYS_STATUS, 8'h01);
        #1 compare({3'h0, acc}, 8'h03);
        w(`ADDR_SYS_STATUS, 8'h00);
        w(`ADDR_PROTECT_CMD, d);
        w(`ADDR_PROTECT_CMD, d);
        w(`ADDR_POWER_SAVE, 8'hC3);
        cpu.op(1, 0, `ADDR_PROTECT_CMD, d, `SIZE_HALF);
        w(`ADDR_POWER_SAVE, 8'h3C);
        r(`ADDR_POWER_SAVE, 8'h5A);
        r(`ADDR_SYS_STATUS, 8'h01);
        w(`ADDR_PROTECT_CMD, d);
        reset_n_in <= 0;
        repeat (2) cpu.op(0, 0, 0, 0, 0);
        reset_n_in <= 1;
        r(`ADDR_SYS_STATUS, `RST_SYS_STATUS);
        #1 compare({7'h00, hold}, 8'h00);
        r(`ADDR_WAIT_CTRL, `RST_WAIT_CTRL);
        w(`ADDR_WAIT_CTRL, 8'h01);
        w(`ADDR_POWER_SAVE, 8'h77);
        r(`ADDR_POWER_SAVE, `RST_POWER_SAVE);
        r(`ADDR_SYS_STATUS, 8'h01);
        cpu.op(0, 0, 0, 0, 0);
        cpu.op(0, 0, 0, 0, 0);
        stop_test();
    end
endmodule // protected_register_write_guard_test
